// file: rtl/ptc_pkg.sv
// constants for the fast paper tape controller
package ptc_pkg;
  // receiver command words (low byte of the command)
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_STOP = 8'h02;
  localparam logic [7:0] CMD_INH = 8'h04;
  localparam logic [7:0] CMD_RD_INH = 8'h05;
  localparam logic [7:0] CMD_ST_INH = 8'h06;
  localparam logic [7:0] CMD_ALW = 8'h08;
  localparam logic [7:0] CMD_RD_ALW = 8'h09;
  localparam logic [7:0] CMD_ST_ALW = 8'h0A;
  // command field positions
  localparam int CMD_BIT_READ = 0;
  localparam int CMD_BIT_STOP = 1;
  localparam int CMD_BIT_INH = 2;
  localparam int CMD_BIT_ALW = 3;
  // status byte values
  localparam logic [7:0] STS_DNR = 8'h40;
  localparam logic [7:0] STS_TERR = 8'h04;
  localparam logic [7:0] STS_NONE = 8'h00;
  // default transmitter station address
  localparam logic [7:0] DEF_TX_ADDR = 8'h0A;
  // punch pacing: least period between punch hand-offs
  localparam int CLK_HZ = 50_000_000;
  localparam int PUNCH_BPS = 60;
  localparam int PUNCH_GAP_CYC = (CLK_HZ + PUNCH_BPS - 1) / PUNCH_BPS;
  localparam int PACE_W = 20;
  localparam int BUF_DEPTH = 2;
endpackage

// file: rtl/ptc_controller.sv
// fast paper tape controller: reader receiver and punch transmitter
`timescale 1ns/100ps
module ptc_controller
  import ptc_pkg::*;
#(
  parameter logic [7:0] TX_ADDR = DEF_TX_ADDR,
  parameter int PUNCH_GAP = PUNCH_GAP_CYC,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic cmdOut,
  input wire logic dataIn,
  input wire logic dataOut,
  input wire logic addrIn,
  input wire logic statusIn,
  output logic hostAck,
  output logic [7:0] hostData,
  output logic rxIrq,
  output logic txIrq,
  input wire logic [7:0] rdrChar,
  input wire logic rdrStrobe,
  input wire logic rdrNotReady,
  output logic rdrRun,
  output logic punchValid,
  output logic [7:0] punchData,
  input wire logic punchReady,
  input wire logic punchNotReady
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // elaboration-time checks on the parameters
  if (TX_ADDR[0] != 1'b0 || TX_ADDR == 8'h00) begin : g_bad_addr
    $error("TX_ADDR must be even and non-zero");
  end
  if (DEPTH != (1 << PW) || DEPTH < 2) begin : g_bad_depth
    $error("DEPTH must be a power of two, at least two");
  end
  if (PUNCH_GAP < 2 || PUNCH_GAP >= (1 << PACE_W)) begin : g_bad_gap
    $error("PUNCH_GAP out of range");
  end

  function automatic logic rxCmdValid(input logic [7:0] c);
    return c == CMD_READ || c == CMD_STOP || c == CMD_INH ||
      c == CMD_RD_INH || c == CMD_ST_INH || c == CMD_ALW ||
      c == CMD_RD_ALW || c == CMD_ST_ALW;
  endfunction

  logic [7:0] rxAddr;
  logic rxHit, txHit, rxValidCmd, txValidCmd, punchFire, txTake, pDnr;
  logic [7:0] rxBuf_r, rxBuf_nxt, data_r, data_nxt;
  logic ack_r, ack_nxt, rxValid_r, rxValid_nxt, rxTerr_r, rxTerr_nxt;
  logic rxIntEn_r, rxIntEn_nxt, rxPend_r, rxPend_nxt;
  logic rxDnrIrq_r, rxDnrIrq_nxt, run_r, run_nxt, stopPend_r, stopPend_nxt;
  logic txIntEn_r, txIntEn_nxt, txPend_r, txPend_nxt;
  logic txDnrIrq_r, txDnrIrq_nxt, punchDnr_r, punchDnr_nxt;
  logic [PACE_W-1:0] pace_r, pace_nxt;
  logic [7:0] buf_r [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;

  assign rxAddr = TX_ADDR | 8'h01;
  assign rxHit = busAddr == rxAddr;
  assign txHit = busAddr == TX_ADDR;
  assign rxValidCmd = cmdOut && rxHit && rxCmdValid(busWrData);
  assign txValidCmd = cmdOut && txHit &&
    (busWrData == CMD_INH || busWrData == CMD_ALW);
  assign pDnr = punchNotReady || punchDnr_r;
  // punch hand-off paced by the gap counter
  assign punchValid = cnt_r != '0 && pace_r == '0;
  assign punchData = buf_r[rp_r];
  assign punchFire = punchValid && punchReady;
  // non-interrupt mode takes a byte only once the previous one is punched
  assign txTake = dataOut && txHit && cnt_r < (PW+1)'(DEPTH) &&
    (txIntEn_r || cnt_r == '0);
  assign hostAck = ack_r;
  assign hostData = data_r; // bit 7 is line 8
  assign rxIrq = (rxIntEn_r && rxPend_r) || rxDnrIrq_r;
  assign txIrq = txIntEn_r && (txPend_r || txDnrIrq_r);
  assign rdrRun = run_r;

  always_comb begin
    rxBuf_nxt = rxBuf_r;
    rxValid_nxt = rxValid_r;
    rxTerr_nxt = rxTerr_r;
    rxIntEn_nxt = rxIntEn_r;
    rxPend_nxt = rxPend_r;
    rxDnrIrq_nxt = rxDnrIrq_r;
    run_nxt = run_r;
    stopPend_nxt = stopPend_r;
    txIntEn_nxt = txIntEn_r;
    txPend_nxt = txPend_r;
    txDnrIrq_nxt = txDnrIrq_r;
    punchDnr_nxt = punchDnr_r;
    ack_nxt = 1'b0;
    data_nxt = data_r;
    // host requests to the receiver
    if (rxValidCmd) begin
      ack_nxt = 1'b1;
      rxTerr_nxt = 1'b0;
      if (busWrData[CMD_BIT_READ]) begin
        run_nxt = 1'b1;
        stopPend_nxt = 1'b0;
        if (rdrNotReady)
          rxDnrIrq_nxt = 1'b1;
      end
      if (busWrData[CMD_BIT_STOP])
        stopPend_nxt = 1'b1;
      if (busWrData[CMD_BIT_INH])
        rxIntEn_nxt = 1'b0;
      if (busWrData[CMD_BIT_ALW])
        rxIntEn_nxt = 1'b1;
    end
    if (dataIn && rxHit) begin
      data_nxt = rxBuf_r;
      if (rxValid_r && !rxTerr_r && !rxDnrIrq_r) begin
        ack_nxt = 1'b1;
        rxValid_nxt = 1'b0;
      end // otherwise refused
      rxPend_nxt = 1'b0;
      if (rxIntEn_r)
        rxDnrIrq_nxt = 1'b0;
    end
    if (statusIn && rxHit) begin
      data_nxt = (rdrNotReady ? STS_DNR : STS_NONE) |
        (rxTerr_r ? STS_TERR : STS_NONE);
      rxTerr_nxt = 1'b0;
      rxPend_nxt = 1'b0;
      rxDnrIrq_nxt = 1'b0;
    end
    // address-input: receiver has priority, no acknowledge
    if (addrIn) begin
      if (rxIrq) begin
        data_nxt = rxAddr;
        rxPend_nxt = 1'b0;
        rxDnrIrq_nxt = 1'b0;
      end else if (txIrq) begin
        data_nxt = TX_ADDR;
        txPend_nxt = 1'b0;
        txDnrIrq_nxt = 1'b0;
      end
    end
    // host requests to the transmitter
    if (txValidCmd) begin
      ack_nxt = 1'b1;
      txIntEn_nxt = busWrData[CMD_BIT_ALW];
    end
    if (statusIn && txHit) begin
      data_nxt = pDnr ? STS_DNR : STS_NONE;
      punchDnr_nxt = 1'b0;
      txPend_nxt = 1'b0;
      txDnrIrq_nxt = 1'b0;
    end
    if (txTake) begin
      if (pDnr) begin
        if (txIntEn_r)
          txDnrIrq_nxt = 1'b1;
      end else begin
        ack_nxt = 1'b1;
        txPend_nxt = 1'b0;
      end
    end
    // hardware events win over clears in the same cycle
    if (punchNotReady)
      punchDnr_nxt = 1'b1;
    if (punchFire)
      txPend_nxt = 1'b1;
    if (rdrStrobe) begin
      rxBuf_nxt = rdrChar;
      if (rxValid_r)
        rxTerr_nxt = 1'b1;
      rxValid_nxt = 1'b1;
      rxPend_nxt = 1'b1;
      if (stopPend_r) begin
        run_nxt = 1'b0;
        stopPend_nxt = 1'b0;
      end
    end
  end

  // punch byte buffer and pacing
  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    pace_nxt = pace_r;
    if (pace_r != '0)
      pace_nxt = pace_r - 1'b1;
    if (txTake)
      wp_nxt = wp_r + 1'b1;
    if (punchFire) begin
      rp_nxt = rp_r + 1'b1;
      pace_nxt = PACE_W'(PUNCH_GAP - 1);
    end
    cnt_nxt = cnt_r + (PW+1)'(txTake) - (PW+1)'(punchFire);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rxBuf_r <= 8'h00;
      rxValid_r <= 1'b0;
      rxTerr_r <= 1'b0;
      rxIntEn_r <= 1'b0;
      rxPend_r <= 1'b0;
      rxDnrIrq_r <= 1'b0;
      run_r <= 1'b0;
      stopPend_r <= 1'b0;
      txIntEn_r <= 1'b0;
      txPend_r <= 1'b0;
      txDnrIrq_r <= 1'b0;
      punchDnr_r <= 1'b0;
      ack_r <= 1'b0;
      data_r <= 8'h00;
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      pace_r <= '0;
    end else if (ce) begin
      rxBuf_r <= rxBuf_nxt;
      rxValid_r <= rxValid_nxt;
      rxTerr_r <= rxTerr_nxt;
      rxIntEn_r <= rxIntEn_nxt;
      rxPend_r <= rxPend_nxt;
      rxDnrIrq_r <= rxDnrIrq_nxt;
      run_r <= run_nxt;
      stopPend_r <= stopPend_nxt;
      txIntEn_r <= txIntEn_nxt;
      txPend_r <= txPend_nxt;
      txDnrIrq_r <= txDnrIrq_nxt;
      punchDnr_r <= punchDnr_nxt;
      ack_r <= ack_nxt;
      data_r <= data_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      pace_r <= pace_nxt;
      if (txTake)
        buf_r[wp_r] <= busWrData;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // a single host strobe, so no other request overrides the answer
  logic oneReq;
  assign oneReq = $onehot({cmdOut, dataIn, dataOut, addrIn, statusIn});

  property p_cmd_ack;
    ce && cmdOut && rxHit && rxCmdValid(busWrData) |=> hostAck;
  endproperty
  a_cmd_ack: assert property (p_cmd_ack) else $error("cmd not acked");
  property p_terr_set;
    ce && rdrStrobe && rxValid_r |=> rxTerr_r;
  endproperty
  a_terr_set: assert property (p_terr_set) else $error("no timing error");
  property p_edi_terr;
    ce && oneReq && dataIn && rxHit && rxTerr_r && !rdrStrobe
      |=> !hostAck && hostData == $past(rxBuf_r) && !rxPend_r;
  endproperty
  a_edi_terr: assert property (p_edi_terr) else $error("bad edi in error");
  property p_edi_ok;
    ce && oneReq && dataIn && rxHit && rxValid_r && !rxTerr_r &&
      !rxDnrIrq_r
      |=> hostAck && hostData == $past(rxBuf_r);
  endproperty
  a_edi_ok: assert property (p_edi_ok) else $error("edi not served");
  property p_no_data;
    ce && oneReq && dataIn && rxHit && !rxValid_r |=> !hostAck;
  endproperty
  a_no_data: assert property (p_no_data) else $error("edi acked empty");
  property p_rx_sts;
    ce && oneReq && statusIn && rxHit && !rdrStrobe |=> !hostAck &&
      hostData[6] == $past(rdrNotReady) && hostData[2] == $past(rxTerr_r)
      && !rxTerr_r;
  endproperty
  a_rx_sts: assert property (p_rx_sts) else $error("rx status wrong");
  property p_pace;
    ce && punchFire |=> !punchValid [*2];
  endproperty
  a_pace: assert property (p_pace) else $error("punch not paced");
  property p_tx_irq;
    ce && punchFire && txIntEn_r && !txValidCmd |=> txIrq;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("no tx irq");
  property p_rd_dnr;
    ce && rxValidCmd && busWrData[CMD_BIT_READ] && rdrNotReady
      |=> rxIrq && hostAck;
  endproperty
  a_rd_dnr: assert property (p_rd_dnr) else $error("dnr read wrong");
  property p_eai;
    ce && oneReq && addrIn && rxIrq
      |=> !hostAck && hostData == rxAddr;
  endproperty
  a_eai: assert property (p_eai) else $error("eai wrong");
  property p_stop;
    ce && rdrStrobe && stopPend_r && !rxValidCmd |=> !rdrRun;
  endproperty
  a_stop: assert property (p_stop) else $error("reader not stopped");

  c_punch: cover property (ce && punchFire);
  c_overrun: cover property (ce && rdrStrobe && rxValid_r);
  c_buf_full: cover property (cnt_r == (PW+1)'(DEPTH));
endmodule

// file: bench/ptc_tape_model.sv
// reader and punch model standing behind the controller
`timescale 1ns/100ps
module ptc_tape_model (
  input wire logic mclk,
  input wire logic stall,
  output logic [7:0] rdrChar,
  output logic rdrStrobe,
  input wire logic punchValid,
  input wire logic [7:0] punchData,
  output logic punchReady
);
  logic [7:0] punched[$];
  int cyc = 0;
  int lastAt = -1000;
  int minGap = 1000;
  initial begin
    rdrChar = 8'hFF;
    rdrStrobe = 1'b0;
  end
  // a stalled punch holds ready low
  assign punchReady = !stall;
  // one reader character, lines inverted once the strobe ends
  task automatic send(input logic [7:0] c);
    @(posedge mclk);
    rdrChar <= c;
    rdrStrobe <= 1'b1;
    @(posedge mclk);
    rdrChar <= ~c;
    rdrStrobe <= 1'b0;
  endtask
  // record each hand-off and the shortest spacing seen
  always @(posedge mclk) begin
    cyc++;
    if (punchValid && punchReady) begin
      punched.push_back(punchData);
      if (cyc - lastAt < minGap) minGap = cyc - lastAt;
      lastAt = cyc;
    end
  end
endmodule

// file: bench/tb_ptc_controller.sv
// self-checking bench for the paper tape controller
`timescale 1ns/100ps
module tb_ptc_controller;
  import ptc_pkg::*;
  localparam logic [7:0] TXA = 8'h0A;
  localparam logic [7:0] RXA = 8'h0B;
  localparam int GAP = 8;
  logic mclk, rst, ce, rdrNotReady, punchNotReady, stall, ack;
  logic hostAck, rxIrq, txIrq, rdrStrobe, rdrRun, punchValid, punchReady;
  logic [4:0] stb;
  logic [7:0] busAddr, busWrData, hostData, rdrChar, punchData, q;
  logic [7:0] cmds [8] = '{CMD_READ, CMD_STOP, CMD_INH, CMD_RD_INH,
    CMD_ST_INH, CMD_ALW, CMD_RD_ALW, CMD_ST_ALW};
  logic [7:0] pexp [6] = '{8'h3C, 8'h3D, 8'h3E, 8'h41, 8'h50, 8'h52};
  int num_errors = 0;
  int n_tests = 0;
  ptc_controller #(.TX_ADDR(TXA), .PUNCH_GAP(GAP)) i_dut (
    .mclk(mclk), .rst(rst), .ce(ce), .busAddr(busAddr),
    .busWrData(busWrData), .cmdOut(stb[0]), .dataIn(stb[1]),
    .dataOut(stb[2]), .addrIn(stb[3]), .statusIn(stb[4]),
    .hostAck(hostAck), .hostData(hostData), .rxIrq(rxIrq), .txIrq(txIrq),
    .rdrChar(rdrChar), .rdrStrobe(rdrStrobe), .rdrNotReady(rdrNotReady),
    .rdrRun(rdrRun), .punchValid(punchValid), .punchData(punchData),
    .punchReady(punchReady), .punchNotReady(punchNotReady));
  ptc_tape_model i_tape (.mclk(mclk), .stall(stall), .rdrChar(rdrChar),
    .rdrStrobe(rdrStrobe), .punchValid(punchValid),
    .punchData(punchData), .punchReady(punchReady));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  // one strobe: 0 cmd, 1 data in, 2 data out, 3 address in, 4 status in
  task automatic rq(input int k, input logic [7:0] a, input logic [7:0] d,
    input logic ea);
    @(posedge mclk);
    busAddr <= a;
    busWrData <= d;
    stb <= 5'h01 << k;
    @(posedge mclk);
    stb <= 5'h00;
    #1;
    ack = hostAck;
    q = hostData;
    chb(ack, ea);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [7:0] c);
    i_tape.send(c);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    stb = 5'h00;
    busAddr = 8'h00;
    busWrData = 8'h00;
    rdrNotReady = 1'b0;
    punchNotReady = 1'b0;
    stall = 1'b0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chb(rxIrq | txIrq | rdrRun, 1'b0);
    rq(1, RXA, 8'h00, 1'b0);
    rq(0, RXA, 8'h03, 1'b0);
    rq(0, TXA, CMD_READ, 1'b0);
    foreach (cmds[i]) rq(0, RXA, cmds[i], 1'b1);
    chb(rdrRun, 1'b1);
    rd(8'hA5);
    chb(rxIrq, 1'b1);
    chb(rdrRun, 1'b0);
    rq(1, RXA, 8'h00, 1'b1);
    chk(q, 8'hA5);
    chb(rxIrq, 1'b0);
    rq(1, RXA, 8'h00, 1'b0);
    rq(0, RXA, CMD_RD_ALW, 1'b1);
    rd(8'hC3);
    rq(3, RXA, 8'h00, 1'b0);
    chk(q, RXA);
    chb(rxIrq, 1'b0);
    rq(1, RXA, 8'h00, 1'b1);
    chk(q, 8'hC3);
    rd(8'h11);
    rd(8'h22);
    rq(1, RXA, 8'h00, 1'b0);
    chk(q, 8'h22);
    chb(rxIrq, 1'b0);
    rq(4, RXA, 8'h00, 1'b0);
    chk(q, STS_TERR);
    rq(4, RXA, 8'h00, 1'b0);
    chk(q, STS_NONE);
    rdrNotReady <= 1'b1;
    rq(0, RXA, CMD_READ, 1'b1);
    chb(rxIrq, 1'b1);
    rq(4, RXA, 8'h00, 1'b0);
    chk(q, STS_DNR);
    chb(rxIrq, 1'b0);
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    #1;
    chb(rdrRun | rxIrq | txIrq, 1'b0);
    rdrNotReady <= 1'b0;
    rq(0, RXA, CMD_RD_INH, 1'b1);
    rd(8'h5A);
    chb(rxIrq, 1'b0);
    rq(1, RXA, 8'h00, 1'b1);
    chk(q, 8'h5A);
    rd(8'h66);
    rd(8'h77);
    rq(1, RXA, 8'h00, 1'b0);
    chk(q, 8'h77);
    rdrNotReady <= 1'b1;
    rq(0, RXA, CMD_RD_INH, 1'b1);
    chb(rxIrq, 1'b1);
    rq(1, RXA, 8'h00, 1'b0);
    chb(rxIrq, 1'b1);
    rq(4, RXA, 8'h00, 1'b0);
    chk(q, STS_DNR);
    chb(rxIrq, 1'b0);
    rdrNotReady <= 1'b0;
    rq(0, TXA, CMD_ALW, 1'b1);
    rq(2, TXA, 8'h3C, 1'b1);
    wt(4);
    chb(txIrq, 1'b1);
    chb(rxIrq, 1'b0);
    stall <= 1'b1;
    rq(2, TXA, 8'h3D, 1'b1);
    chb(txIrq, 1'b0);
    rq(2, TXA, 8'h3E, 1'b1);
    rq(2, TXA, 8'h3F, 1'b0);
    stall <= 1'b0;
    wt(4 * GAP);
    chb(i_tape.minGap >= GAP, 1'b1);
    rq(3, TXA, 8'h00, 1'b0);
    chk(q, TXA);
    chb(txIrq, 1'b0);
    punchNotReady <= 1'b1;
    rq(2, TXA, 8'h41, 1'b0);
    chb(txIrq, 1'b1);
    punchNotReady <= 1'b0;
    wt(2 * GAP);
    rq(4, TXA, 8'h00, 1'b0);
    chk(q, STS_DNR);
    chb(txIrq, 1'b0);
    rq(4, TXA, 8'h00, 1'b0);
    chk(q, STS_NONE);
    rq(0, TXA, CMD_INH, 1'b1);
    stall <= 1'b1;
    rq(2, TXA, 8'h50, 1'b1);
    rq(2, TXA, 8'h51, 1'b0);
    stall <= 1'b0;
    wt(2 * GAP);
    chb(txIrq, 1'b0);
    rq(2, TXA, 8'h52, 1'b1);
    wt(2 * GAP);
    chk(8'(i_tape.punched.size()), 8'h06);
    foreach (pexp[i]) chk(i_tape.punched[i], pexp[i]);
    give_verdict();
  end
endmodule
